//--- pkg/frs_pkg.sv
// constants, field layouts and carrier types of the fault restart/retry sequencer
package frs_pkg;
	localparam int NUM_CH = 2;
	// command codes
	localparam logic [7:0] CMD_PAGE = 8'h00;
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_OUT_OV_RESP = 8'h41;
	localparam logic [7:0] CMD_OUT_UV_RESP = 8'h45;
	localparam logic [7:0] CMD_IN_OV_RESP = 8'h56;
	localparam logic [7:0] CMD_TON_MAX_RESP = 8'h63;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_STATUS_VOUT = 8'h7A;
	localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
	localparam logic [7:0] CMD_STATUS_CML = 8'h7E;
	localparam logic [7:0] CMD_CHAN_CONFIG = 8'hD0;
	localparam logic [7:0] CMD_ALERT_MASK = 8'hD8;
	localparam logic [7:0] CMD_RETRY_INTERVAL = 8'hDB;
	localparam logic [7:0] CMD_RUN_OFF_HOLD = 8'hDC;
	localparam logic [7:0] PAGE_ALL = 8'hFF;
	// slots of the per-channel setting memory
	localparam int SLOT_W = 3;
	localparam logic [2:0] SLOT_OUT_OV = 3'h0;
	localparam logic [2:0] SLOT_OUT_UV = 3'h1;
	localparam logic [2:0] SLOT_IN_OV = 3'h2;
	localparam logic [2:0] SLOT_TON_MAX = 3'h3;
	localparam logic [2:0] SLOT_RETRY = 3'h4;
	localparam logic [2:0] SLOT_HOLD = 3'h5;
	localparam logic [2:0] SLOT_CONFIG = 3'h6;
	localparam logic [2:0] SLOT_OPER = 3'h7;
	// reset values
	localparam logic [15:0] RST_OUT_OV = 16'h00B8;
	localparam logic [15:0] RST_OUT_UV = 16'h00B8;
	localparam logic [15:0] RST_IN_OV = 16'h0080;
	localparam logic [15:0] RST_TON_MAX = 16'h00B8;
	localparam logic [15:0] RST_RETRY = 16'hFABC;
	localparam logic [15:0] RST_HOLD = 16'hFBE8;
	localparam logic [15:0] RST_CONFIG = 16'h0000;
	localparam logic [15:0] RST_OPER = 16'h0080;
	localparam logic [7:0] RST_ALERT_MASK = 8'h00;
	// field positions
	localparam int OPER_ON_BIT = 7;
	localparam int CFG_NO_RETRY_DECAY_BIT = 0;
	localparam int CFG_HOLD_DECAY_BIT = 1;
	localparam int MASK_IN_OV_BIT = 0;
	localparam int MASK_OUT_OV_BIT = 1;
	localparam int MASK_CML_BIT = 2;
	localparam int SB_OUT_OV_BIT = 5;
	localparam int SB_OTHER_BIT = 0;
	localparam int SB_CML_BIT = 1;
	localparam int SW_OUT_BIT = 15;
	localparam int SW_IN_BIT = 13;
	localparam int SV_OUT_OV_BIT = 7;
	localparam int SI_IN_OV_BIT = 7;
	localparam int SC_BAD_DATA_BIT = 6;
	// response byte fields
	localparam logic [1:0] RESP_IGNORE = 2'b00;
	localparam logic [1:0] RESP_DEGLITCH = 2'b01;
	localparam logic [1:0] RESP_SHUTDOWN = 2'b10;
	localparam logic [2:0] RETRY_NONE = 3'b000;
	localparam logic [2:0] RETRY_ALWAYS = 3'b111;
	// delay ranges in ms
	localparam logic [16:0] HOLD_MIN_MS = 17'd136;
	localparam logic [16:0] HOLD_MAX_MS = 17'd65520;
	localparam logic [16:0] HOLD_STEP_MS = 17'd16;
	localparam logic [16:0] RETRY_MIN_MS = 17'd120;
	localparam logic [16:0] RETRY_MAX_MS = 17'd83880;
	// timing
	localparam int CLK_PERIOD_PS = 10000;
	localparam int MS_TICK_PS = 1000000000;
	localparam int DEGLITCH_UNIT_PS = 10000000;
	localparam int MS_TICK_CYCLES = MS_TICK_PS / CLK_PERIOD_PS;
	localparam int DEGLITCH_CYCLES = DEGLITCH_UNIT_PS / CLK_PERIOD_PS;

	typedef enum {ST_OFF, ST_HOLD, ST_ON, ST_GLITCH, ST_RETRY, ST_LATCHED} frs_state_t;

	// one command transaction from the serial engine
	typedef struct packed {
		logic [7:0] code;
		logic [15:0] data;
	} frs_cmd_t;

	// decoded fault response byte
	typedef struct packed {
		logic [1:0] action;
		logic [2:0] retry;
		logic [2:0] delay;
	} frs_resp_t;
endpackage

//--- rtl/frs_cfg_mem.sv
// per-channel setting memory with registered read data
`timescale 1ns/1ps
module frs_cfg_mem #(
	parameter int CH = 2,
	parameter int SLOTS = 8
) (
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	input wire logic [CH-1:0] WE_I,
	input wire logic [$clog2(SLOTS)-1:0] WSLOT_I,
	input wire logic [15:0] WDATA_I,
	input wire logic [$clog2(CH)-1:0] RCH_I,
	input wire logic [$clog2(SLOTS)-1:0] RSLOT_I,
	output logic [15:0] RDATA_O
);
	import frs_pkg::*;

	logic [15:0] mem_r [CH][SLOTS];

	// reset contents match the power-up defaults of each setting
	function automatic logic [15:0] slot_reset(input int s);
		case (s)
			0: slot_reset = RST_OUT_OV;
			1: slot_reset = RST_OUT_UV;
			2: slot_reset = RST_IN_OV;
			3: slot_reset = RST_TON_MAX;
			4: slot_reset = RST_RETRY;
			5: slot_reset = RST_HOLD;
			6: slot_reset = RST_CONFIG;
			default: slot_reset = RST_OPER;
		endcase
	endfunction

	// storage, written per channel mask
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			for (int c = 0; c < CH; c++) begin
				for (int s = 0; s < SLOTS; s++) begin
					mem_r[c][s] <= slot_reset(s);
				end
			end
		end else begin
			for (int c = 0; c < CH; c++) begin
				if (WE_I[c]) begin
					mem_r[c][WSLOT_I] <= WDATA_I;
				end
			end
		end
	end

	// read port, one cycle latency
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RDATA_O <= 16'h0000;
		end else begin
			RDATA_O <= mem_r[RCH_I][RSLOT_I];
		end
	end
endmodule

//--- rtl/frs_sequencer.sv
// fault restart and retry sequencer for two output channels
//
// Overview of operation
// - on a falling run edge, drive run low for the run-off hold time.
// - after the hold ends and run is released, start the channel normally.
// - hold time spans 136ms to 65.52s in 16ms steps.
// - with decay wait enabled, start also waits for output below 12.5%.
// - both delay settings are linear 5-bit exponent, 11-bit mantissa words.
// - one retry interval per channel serves every retrying response.
// - retry interval timing starts when the fault is detected.
// - retry interval spans 120ms to 83.88s in 1ms steps.
// - retry waits for interval and decay; config bit 0 drops decay wait.
// - input overvoltage sets other-fault, input, input-ov status and alert.
// - output overvoltage sets ov summary, output, output-ov status and alert.
// - response 0x80 shuts down, no retry, off until faults cleared.
// - response 0xB8 shuts down and retries without limit.
// - response 0x4n latches off after n*10us persistent overvoltage.
// - response 0x78+n shuts down after n*10us and retries continuously.
// - unsupported ov response write is ignored and raises a logic fault.
// - response bits 7:6 action, 5:3 retry, 2:0 deglitch in 10us.
// - status clears only by clear-faults, off-then-on, run pin rising, or power cycle.
`timescale 1ns/1ps
module frs_sequencer #(
	parameter int TICK_CYCLES = frs_pkg::MS_TICK_CYCLES,
	parameter int GLITCH_CYCLES = frs_pkg::DEGLITCH_CYCLES
) (
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	input wire logic CMD_WR_I,
	input wire logic CMD_RD_I,
	input frs_pkg::frs_cmd_t CMD_I,
	output logic [15:0] CMD_RDATA_O,
	output logic CMD_RVALID_O,
	input wire logic [frs_pkg::NUM_CH-1:0] RUN_I,
	output logic [frs_pkg::NUM_CH-1:0] RUN_O,
	output logic [frs_pkg::NUM_CH-1:0] RUN_OE_O,
	input wire logic VIN_OV_I,
	input wire logic [frs_pkg::NUM_CH-1:0] OUTPUT_OVERVOLTAGE_SUMMARY_BIT_I,
	input wire logic [frs_pkg::NUM_CH-1:0] DECAY_LOW_I,
	output logic [frs_pkg::NUM_CH-1:0] CHAN_EN_O,
	output logic [frs_pkg::NUM_CH-1:0] START_O,
	output logic ALERT_O,
	output logic ALERT_OE_O
);
	import frs_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int GW = $clog2(GLITCH_CYCLES + 1);

	////////////////////////////////////////////////////////////////////////////////
	// functions

	// linear word to whole ms; negative values read as zero
	function automatic logic [16:0] l11_to_ms(input logic [15:0] w);
		logic [4:0] e;
		logic [4:0] ne;
		logic [47:0] v;
		e = w[15:11];
		ne = 5'(~w[15:11] + 5'h01);
		v = {37'h0, w[10:0]};
		if (w[10]) begin
			v = 48'h0;
		end else if (e[4]) begin
			v = v >> ne;
		end else begin
			v = v << e;
		end
		l11_to_ms = (v > 48'h1FFFF) ? 17'h1FFFF : v[16:0];
	endfunction

	function automatic logic [16:0] clamp(input logic [16:0] v, input logic [16:0] lo, input logic [16:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// hold rounded up to a 16ms step; capped first so the sum cannot wrap
	function automatic logic [16:0] hold_ms_of(input logic [15:0] w);
		logic [16:0] m;
		m = clamp(l11_to_ms(w), 17'd0, HOLD_MAX_MS);
		hold_ms_of = clamp((m + HOLD_STEP_MS - 17'd1) & ~(HOLD_STEP_MS - 17'd1), HOLD_MIN_MS, HOLD_MAX_MS);
	endfunction

	localparam logic [16:0] RETRY_RST_MS = clamp(l11_to_ms(RST_RETRY), RETRY_MIN_MS, RETRY_MAX_MS);
	localparam logic [16:0] HOLD_RST_MS = hold_ms_of(RST_HOLD);

	// only 0x80, 0xB8, 0x40..0x47 and 0x78..0x7F are accepted
	function automatic logic resp_ok(input logic [7:0] b);
		resp_ok = (b == 8'h80) || (b == 8'hB8) || (b[7:3] == 5'b01000) || (b[7:3] == 5'b01111);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [NUM_CH-1:0] run_m_r, run_s_r, run_d_r, ov_m_r, ov_s_r, dec_m_r, dec_s_r;
	logic vin_m_r, vin_s_r;

	// two flops on every asynchronous pin before any use
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			run_m_r <= '0;
			run_s_r <= '0;
			run_d_r <= '0;
			ov_m_r <= '0;
			ov_s_r <= '0;
			dec_m_r <= '0;
			dec_s_r <= '0;
			vin_m_r <= 1'b0;
			vin_s_r <= 1'b0;
		end else begin
			run_m_r <= RUN_I;
			run_s_r <= run_m_r;
			run_d_r <= run_s_r;
			ov_m_r <= OUTPUT_OVERVOLTAGE_SUMMARY_BIT_I;
			ov_s_r <= ov_m_r;
			dec_m_r <= DECAY_LOW_I;
			dec_s_r <= dec_m_r;
			vin_m_r <= VIN_OV_I;
			vin_s_r <= vin_m_r;
		end
	end

	logic [NUM_CH-1:0] run_fall;
	assign run_fall = run_d_r & ~run_s_r;

	////////////////////////////////////////////////////////////////////////////////
	// time base: 1ms and 10us enables

	logic [TW-1:0] ms_cnt_r;
	logic [GW-1:0] us_cnt_r;
	logic ms_tick, us_tick;
	assign ms_tick = (ms_cnt_r == TW'(TICK_CYCLES - 1));
	assign us_tick = (us_cnt_r == GW'(GLITCH_CYCLES - 1));

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ms_cnt_r <= '0;
			us_cnt_r <= '0;
		end else begin
			ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + TW'(1);
			us_cnt_r <= us_tick ? '0 : us_cnt_r + GW'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// command decode and settings

	logic [7:0] page_r;
	logic [NUM_CH-1:0] pg_sel;
	logic resp_cmd, resp_bad, store_wr, clr_cmd;
	logic [SLOT_W-1:0] wslot, rslot;
	logic [SLOT_W:0] slot_hit;
	logic [7:0] alert_mask_r;
	logic [7:0] out_ov_resp_r [NUM_CH];
	logic [7:0] in_ov_resp_r [NUM_CH];
	logic [16:0] retry_ms_r [NUM_CH];
	logic [16:0] hold_ms_r [NUM_CH];
	logic [15:0] cfg_r [NUM_CH];
	logic [NUM_CH-1:0] oper_on_r, oper_prev_r;
	logic [15:0] mem_rdata;

	// page 0xFF addresses both channels at once for writes and clears; reads then see channel 1
	assign pg_sel = (page_r == PAGE_ALL) ? '1 : (NUM_CH'(1) << page_r[0]);
	assign resp_cmd = (CMD_I.code == CMD_OUT_OV_RESP) || (CMD_I.code == CMD_IN_OV_RESP);
	assign resp_bad = CMD_WR_I && resp_cmd && !resp_ok(CMD_I.data[7:0]);
	assign clr_cmd = CMD_WR_I && (CMD_I.code == CMD_CLEAR_FAULTS);

	// slot of a paged setting; read and write share the decode
	function automatic logic [SLOT_W:0] slot_of(input logic [7:0] code);
		if (code == CMD_OUT_OV_RESP) begin
			slot_of = {1'b1, SLOT_OUT_OV};
		end else if (code == CMD_OUT_UV_RESP) begin
			slot_of = {1'b1, SLOT_OUT_UV};
		end else if (code == CMD_IN_OV_RESP) begin
			slot_of = {1'b1, SLOT_IN_OV};
		end else if (code == CMD_TON_MAX_RESP) begin
			slot_of = {1'b1, SLOT_TON_MAX};
		end else if (code == CMD_RETRY_INTERVAL) begin
			slot_of = {1'b1, SLOT_RETRY};
		end else if (code == CMD_RUN_OFF_HOLD) begin
			slot_of = {1'b1, SLOT_HOLD};
		end else if (code == CMD_CHAN_CONFIG) begin
			slot_of = {1'b1, SLOT_CONFIG};
		end else if (code == CMD_OPERATION) begin
			slot_of = {1'b1, SLOT_OPER};
		end else begin
			slot_of = {1'b0, SLOT_OUT_OV};
		end
	endfunction

	assign slot_hit = slot_of(CMD_I.code);
	assign wslot = slot_hit[SLOT_W-1:0];
	assign rslot = wslot;
	assign store_wr = CMD_WR_I && slot_hit[SLOT_W] && !resp_bad;

	frs_cfg_mem #(.CH(NUM_CH), .SLOTS(1 << SLOT_W)) u_mem (
		.SYS_CLK_I(SYS_CLK_I),
		.RESET_N_I(RESET_N_I),
		.WE_I(store_wr ? pg_sel : '0),
		.WSLOT_I(wslot),
		.WDATA_I(CMD_I.data),
		.RCH_I(page_r[0]),
		.RSLOT_I(rslot),
		.RDATA_O(mem_rdata)
	);

	// page and alert mask are global
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			page_r <= 8'h00;
			alert_mask_r <= RST_ALERT_MASK;
		end else if (CMD_WR_I && CMD_I.code == CMD_PAGE) begin
			page_r <= CMD_I.data[7:0];
		end else if (CMD_WR_I && CMD_I.code == CMD_ALERT_MASK) begin
			alert_mask_r <= CMD_I.data[7:0];
		end
	end

	// working copies; delays held as ms counts so timers never re-decode
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			for (int c = 0; c < NUM_CH; c++) begin
				out_ov_resp_r[c] <= RST_OUT_OV[7:0];
				in_ov_resp_r[c] <= RST_IN_OV[7:0];
				retry_ms_r[c] <= RETRY_RST_MS;
				hold_ms_r[c] <= HOLD_RST_MS;
				cfg_r[c] <= RST_CONFIG;
				oper_on_r[c] <= RST_OPER[OPER_ON_BIT];
			end
		end else if (store_wr) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (pg_sel[c]) begin
					if (CMD_I.code == CMD_OUT_OV_RESP) out_ov_resp_r[c] <= CMD_I.data[7:0];
					if (CMD_I.code == CMD_IN_OV_RESP) in_ov_resp_r[c] <= CMD_I.data[7:0];
					if (CMD_I.code == CMD_RETRY_INTERVAL)
						retry_ms_r[c] <= clamp(l11_to_ms(CMD_I.data), RETRY_MIN_MS, RETRY_MAX_MS);
					if (CMD_I.code == CMD_RUN_OFF_HOLD)
						hold_ms_r[c] <= hold_ms_of(CMD_I.data);
					if (CMD_I.code == CMD_CHAN_CONFIG) cfg_r[c] <= CMD_I.data;
					if (CMD_I.code == CMD_OPERATION) oper_on_r[c] <= CMD_I.data[OPER_ON_BIT];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-channel sequencer

	frs_state_t st_r [NUM_CH];
	logic [16:0] tmr_r [NUM_CH];
	logic [2:0] glitch_r [NUM_CH];
	logic [NUM_CH-1:0] latch_by_clear_r;
	logic [NUM_CH-1:0] out_ov_st_r, in_ov_st_r, cml_st_r;
	logic [NUM_CH-1:0] fault_now, off_on, is_vin;
	frs_resp_t act [NUM_CH];

	// input overvoltage wins over an output fault in the same cycle
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			is_vin[c] = vin_s_r && (in_ov_resp_r[c][7:6] != RESP_IGNORE);
			act[c] = is_vin[c] ? frs_resp_t'(in_ov_resp_r[c]) : frs_resp_t'(out_ov_resp_r[c]);
			fault_now[c] = is_vin[c] || (ov_s_r[c] && out_ov_resp_r[c][7:6] != RESP_IGNORE);
			off_on[c] = oper_on_r[c] && !oper_prev_r[c];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			oper_prev_r <= '0;
		end else begin
			oper_prev_r <= oper_on_r;
		end
	end

	// sequencing; the hold after a run fall overrides every other state
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			for (int c = 0; c < NUM_CH; c++) begin
				st_r[c] <= ST_OFF;
				tmr_r[c] <= '0;
				glitch_r[c] <= '0;
			end
			latch_by_clear_r <= '0;
			START_O <= '0;
		end else begin
			START_O <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				if (tmr_r[c] != '0 && ms_tick) tmr_r[c] <= tmr_r[c] - 17'd1;
				if (run_fall[c]) begin
					st_r[c] <= ST_HOLD;
					tmr_r[c] <= hold_ms_r[c];
				end else begin
					case (st_r[c])
						ST_OFF: begin
							if (run_s_r[c] && oper_on_r[c] && !fault_now[c]) begin
								st_r[c] <= ST_ON;
								START_O[c] <= 1'b1;
							end
						end
						ST_HOLD: begin
							// decay wait only when enabled; pin stays ours until timer ends
							if (tmr_r[c] == '0 && run_s_r[c] && oper_on_r[c] &&
									(dec_s_r[c] || !cfg_r[c][CFG_HOLD_DECAY_BIT])) begin
								st_r[c] <= ST_ON;
								START_O[c] <= 1'b1;
							end else if (tmr_r[c] == '0 && !oper_on_r[c]) begin
								st_r[c] <= ST_OFF;
							end
						end
						ST_ON: begin
							if (!oper_on_r[c]) begin
								st_r[c] <= ST_OFF;
							end else if (fault_now[c]) begin
								tmr_r[c] <= retry_ms_r[c];
								glitch_r[c] <= act[c].delay;
								st_r[c] <= (act[c].action == RESP_DEGLITCH) ? ST_GLITCH : ST_RETRY;
								if (act[c].action != RESP_DEGLITCH && act[c].retry == RETRY_NONE) begin
									st_r[c] <= ST_LATCHED;
									latch_by_clear_r[c] <= 1'b1;
								end
							end
						end
						ST_GLITCH: begin
							// output keeps running while the fault is qualified
							if (!fault_now[c]) begin
								st_r[c] <= ST_ON;
							end else if (glitch_r[c] == 3'h0) begin
								st_r[c] <= (act[c].retry == RETRY_ALWAYS) ? ST_RETRY : ST_LATCHED;
								latch_by_clear_r[c] <= 1'b0;
							end else if (us_tick) begin
								glitch_r[c] <= glitch_r[c] - 3'h1;
							end
						end
						ST_RETRY: begin
							if (!oper_on_r[c]) begin
								st_r[c] <= ST_OFF;
							end else if (tmr_r[c] == '0 && run_s_r[c] &&
									(dec_s_r[c] || cfg_r[c][CFG_NO_RETRY_DECAY_BIT])) begin
								st_r[c] <= ST_ON;
								START_O[c] <= 1'b1;
							end
						end
						ST_LATCHED: begin
							if (off_on[c] || (clr_cmd && pg_sel[c] && latch_by_clear_r[c])) begin
								st_r[c] <= ST_OFF;
							end
						end
						default: st_r[c] <= ST_OFF;
					endcase
				end
			end
		end
	end

	// run pin is open drain: pulled low only during the hold
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			RUN_O[c] = 1'b0;
			RUN_OE_O[c] = (st_r[c] == ST_HOLD) && (tmr_r[c] != '0);
		end
	end

	// output enable registered from state
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			CHAN_EN_O <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				CHAN_EN_O[c] <= (st_r[c] == ST_ON) || (st_r[c] == ST_GLITCH);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky status; a new fault wins over a clear in the same cycle

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			out_ov_st_r <= '0;
			in_ov_st_r <= '0;
			cml_st_r <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if ((clr_cmd && pg_sel[c]) || off_on[c] || (run_s_r[c] && !run_d_r[c])) begin
					out_ov_st_r[c] <= 1'b0;
					in_ov_st_r[c] <= 1'b0;
					cml_st_r[c] <= 1'b0;
				end
				if (ov_s_r[c]) out_ov_st_r[c] <= 1'b1;
				if (vin_s_r) in_ov_st_r[c] <= 1'b1;
				if (resp_bad && pg_sel[c]) cml_st_r[c] <= 1'b1;
			end
		end
	end

	// alert is open drain, low while any unmasked fault is set
	always_comb begin
		ALERT_O = 1'b0;
		ALERT_OE_O = ((|in_ov_st_r) && !alert_mask_r[MASK_IN_OV_BIT]) ||
			((|out_ov_st_r) && !alert_mask_r[MASK_OUT_OV_BIT]) ||
			((|cml_st_r) && !alert_mask_r[MASK_CML_BIT]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// reads: status from flags, settings from memory, both one cycle late

	logic rd_mem_r;
	logic [15:0] stat_r;
	logic [15:0] sb;
	logic pc;
	assign pc = page_r[0];
	assign sb = {8'h00, 2'b00, out_ov_st_r[pc], 3'b000, cml_st_r[pc], in_ov_st_r[pc]};

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rd_mem_r <= 1'b0;
			stat_r <= 16'h0000;
			CMD_RVALID_O <= 1'b0;
		end else begin
			CMD_RVALID_O <= CMD_RD_I;
			rd_mem_r <= slot_hit[SLOT_W];
			if (CMD_I.code == CMD_STATUS_BYTE) begin
				stat_r <= sb;
			end else if (CMD_I.code == CMD_STATUS_WORD) begin
				stat_r <= sb | (16'(out_ov_st_r[pc]) << SW_OUT_BIT) | (16'(in_ov_st_r[pc]) << SW_IN_BIT);
			end else if (CMD_I.code == CMD_STATUS_VOUT) begin
				stat_r <= 16'(out_ov_st_r[pc]) << SV_OUT_OV_BIT;
			end else if (CMD_I.code == CMD_STATUS_INPUT) begin
				stat_r <= 16'(in_ov_st_r[pc]) << SI_IN_OV_BIT;
			end else if (CMD_I.code == CMD_STATUS_CML) begin
				stat_r <= 16'(cml_st_r[pc]) << SC_BAD_DATA_BIT;
			end else if (CMD_I.code == CMD_PAGE) begin
				stat_r <= {8'h00, page_r};
			end else if (CMD_I.code == CMD_ALERT_MASK) begin
				stat_r <= {8'h00, alert_mask_r};
			end else begin
				stat_r <= 16'h0000;
			end
		end
	end

	assign CMD_RDATA_O = rd_mem_r ? mem_rdata : stat_r;
endmodule

//--- dv/frs_seq_props.sv
// port assertions of the fault restart/retry sequencer
`timescale 1ns/1ps
module frs_seq_props #(parameter int TICK_CYCLES = 10, parameter int GLITCH_CYCLES = 4) (
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	input wire logic CMD_RD_I,
	input wire logic CMD_RVALID_O,
	input wire logic [frs_pkg::NUM_CH-1:0] RUN_I,
	input wire logic [frs_pkg::NUM_CH-1:0] RUN_O,
	input wire logic [frs_pkg::NUM_CH-1:0] RUN_OE_O,
	input wire logic [frs_pkg::NUM_CH-1:0] START_O,
	input wire logic [frs_pkg::NUM_CH-1:0] CHAN_EN_O,
	input wire logic ALERT_O
);
	import frs_pkg::*;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	////////////////////////////////////////////////////////////////
	// a pin fall held long enough to pass the synchroniser
	sequence run_fall;
		$fell(RUN_I[0]) ##1 !RUN_I[0] [*3];
	endsequence
	sequence start_pulse;
		START_O[0] ##1 !START_O[0];
	endsequence
	a_read_answer: assert property (CMD_RD_I |=> CMD_RVALID_O) else $error("read unanswered");
	a_read_cause: assert property (CMD_RVALID_O |-> $past(CMD_RD_I)) else $error("read data unasked");
	a_hold_pull: assert property (run_fall |-> ##[0:2] RUN_OE_O[0]) else $error("run not held");
	a_hold_no_start: assert property (RUN_OE_O[0] |-> !START_O[0]) else $error("start in hold");
	a_start_one: assert property (START_O[0] |-> start_pulse) else $error("start too long");
	a_start_enable: assert property (start_pulse |-> CHAN_EN_O[0]) else $error("no enable");
	a_enable_cause: assert property ($rose(CHAN_EN_O[0]) |-> $past(START_O[0])) else $error("enable unasked");
	a_pins_low: assert property (RUN_O == '0 && !ALERT_O) else $error("pin driven high");
endmodule
bind frs_sequencer frs_seq_props #(.TICK_CYCLES(TICK_CYCLES), .GLITCH_CYCLES(GLITCH_CYCLES)) u_props (
	.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .CMD_RD_I(CMD_RD_I), .CMD_RVALID_O(CMD_RVALID_O),
	.RUN_I(RUN_I), .RUN_O(RUN_O), .RUN_OE_O(RUN_OE_O), .START_O(START_O), .CHAN_EN_O(CHAN_EN_O),
	.ALERT_O(ALERT_O));

//--- dv/frs_host_model.sv
// host model driving the command port one transfer at a time
`timescale 1ns/1ps
module frs_host_model (
	input wire logic clk_i,
	output logic wr_o,
	output logic rd_o,
	output frs_pkg::frs_cmd_t cmd_o
);
	import frs_pkg::*;
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		cmd_o = '0;
	end
	// strobe stands one cycle; bus inverted after so no stale command lingers
	task automatic xfer(input logic rd, input logic [7:0] c, input logic [15:0] d);
		@(posedge clk_i);
		wr_o <= !rd;
		rd_o <= rd;
		cmd_o <= {c, d};
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		cmd_o <= ~{c, d};
	endtask
endmodule

//--- dv/frs_sequencer_tb.sv
// self-checking bench of the fault restart/retry sequencer
`timescale 1ns/1ps
module frs_sequencer_tb;
	import frs_pkg::*;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic rst_n = 1'b0;
	logic vin_ov = 1'b0;
	logic [1:0] run_drv = 2'b11;
	logic [1:0] output_overvoltage_summary_bit = 2'b00;
	logic [1:0] decay = 2'b11;
	logic [1:0] run_oe, run_o, en, start;
	logic wr, rd, rvalid, alert, alert_oe, bad;
	frs_cmd_t cmd;
	logic [15:0] rdata;
	logic [15:0] lfsr = 16'd32319;
	logic [15:0] exp_q[$];
	logic [7:0] b, cur;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	wire [1:0] run_w = run_drv & ~run_oe; // open drain with pull-up
	always #5 clk = ~clk;
	always #80 lclk = ~lclk; // pin events follow an unrelated slow clock
	frs_host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .cmd_o(cmd));
	frs_sequencer #(.TICK_CYCLES(10), .GLITCH_CYCLES(4)) dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
		.CMD_WR_I(wr), .CMD_RD_I(rd), .CMD_I(cmd), .CMD_RDATA_O(rdata), .CMD_RVALID_O(rvalid),
		.RUN_I(run_w), .RUN_O(run_o), .RUN_OE_O(run_oe), .VIN_OV_I(vin_ov), .OUTPUT_OVERVOLTAGE_SUMMARY_BIT_I(output_overvoltage_summary_bit),
		.DECAY_LOW_I(decay), .CHAN_EN_O(en), .START_O(start), .ALERT_O(alert), .ALERT_OE_O(alert_oe));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [16-1:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic w(input logic [7:0] c, input logic [15:0] d);
		host.xfer(1'b0, c, d);
	endtask
	// expected word is queued before the read goes out
	task automatic r(input logic [7:0] c, input logic [15:0] e);
		exp_q.push_back(e);
		host.xfer(1'b1, c, 16'h0000);
	endtask
	// fault pin raised on a slow-clock edge for len cycles
	task automatic pin(input int len, input logic inp);
		@(posedge lclk);
		@(posedge clk);
		if (inp)
			vin_ov <= 1'b1;
		else
			output_overvoltage_summary_bit[0] <= 1'b1;
		repeat (len) @(posedge clk);
		vin_ov <= 1'b0;
		output_overvoltage_summary_bit[0] <= 1'b0;
	endtask
	// bounded wait for a start pulse; n holds the cycles waited
	task automatic wait_start();
		n = 0;
		while (start[0] !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// read monitor takes the oldest note for each answer
	always @(posedge clk) begin
		cyc++;
		if (rvalid === 1'b1 && exp_q.size() > 0)
			chk(rdata, exp_q.pop_front(), "read");
	end
	// ceiling well above the ~7000 cycles the tests need
	always @(posedge clk) begin
		if (cyc > 40000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		w(CMD_PAGE, 16'h00FF);
		r(CMD_OUT_OV_RESP, 16'h00B8);
		r(CMD_IN_OV_RESP, 16'h0080);
		r(CMD_RETRY_INTERVAL, 16'hFABC);
		r(8'h20, 16'h0000);
		$display("reset values done");
		cur = 8'hB8;
		bad = 1'b0;
		for (int i = 0; i < 10; i++) begin
			lfsr = lfsr_next(lfsr);
			b = (i == 0) ? 8'h80 : (i == 1) ? 8'h43 : (i == 2) ? 8'h7B : lfsr[7:0];
			if (b == 8'h80 || b == 8'hB8 || b[7:3] == 5'h08 || b[7:3] == 5'h0F)
				cur = b;
			else
				bad = 1'b1;
			w(CMD_OUT_OV_RESP, {8'h00, b});
			r(CMD_OUT_OV_RESP, {8'h00, cur});
		end
		r(CMD_STATUS_CML, {9'h000, bad, 6'h00});
		chk({15'h0, alert_oe}, {15'h0, bad}, "cml alert");
		w(CMD_CLEAR_FAULTS, 16'h0000);
		r(CMD_STATUS_CML, 16'h0000);
		chk({15'h0, alert_oe}, 16'h0000, "alert clear");
		$display("response codes done");
		w(CMD_CHAN_CONFIG, 16'h0002);
		w(CMD_RUN_OFF_HOLD, 16'h0089);
		@(posedge lclk);
		@(posedge clk);
		run_drv[0] <= 1'b0;
		decay[0] <= 1'b0;
		repeat (8) @(posedge clk);
		run_drv[0] <= 1'b1;
		n = 0;
		while (run_oe[0] === 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0, n >= 1420 && n <= 1452}, 16'h0001, "hold length");
		repeat (40) @(negedge clk);
		chk({15'h0, en[0]}, 16'h0000, "hold decay wait");
		@(posedge clk);
		decay[0] <= 1'b1;
		wait_start();
		chk({15'h0, n < 3000}, 16'h0001, "start after hold");
		$display("hold done");
		w(CMD_PAGE, 16'h0000);
		w(CMD_OUT_OV_RESP, 16'h0080);
		pin(20, 1'b0);
		repeat (2000) @(negedge clk);
		chk({14'h0, en}, 16'h0002, "latched");
		r(CMD_STATUS_BYTE, 16'h0020);
		r(CMD_STATUS_VOUT, 16'h0080);
		chk({15'h0, alert_oe}, 16'h0001, "ov alert");
		w(CMD_CLEAR_FAULTS, 16'h0000);
		wait_start();
		chk({15'h0, n < 3000}, 16'h0001, "clear restart");
		$display("latch done");
		w(CMD_OUT_OV_RESP, 16'h00B8);
		w(CMD_RETRY_INTERVAL, 16'h0078);
		pin(20, 1'b0);
		wait_start();
		chk({15'h0, n >= 1170 && n <= 1205}, 16'h0001, "retry time");
		@(posedge clk);
		decay[0] <= 1'b0;
		pin(20, 1'b0);
		repeat (1600) @(posedge clk);
		chk({15'h0, en[0]}, 16'h0000, "decay wait");
		decay[0] <= 1'b1;
		wait_start();
		chk({15'h0, n < 20}, 16'h0001, "decay start");
		w(CMD_OUT_OV_RESP, 16'h0043);
		pin(4, 1'b0);
		repeat (30) @(negedge clk);
		chk({15'h0, en[0]}, 16'h0001, "deglitch ride");
		pin(40, 1'b0);
		w(CMD_CLEAR_FAULTS, 16'h0000);
		repeat (30) @(negedge clk);
		chk({15'h0, en[0]}, 16'h0000, "latch holds");
		w(CMD_OPERATION, 16'h0000);
		w(CMD_OPERATION, 16'h0080);
		wait_start();
		chk({15'h0, n < 20}, 16'h0001, "off on restart");
		$display("retry done");
		w(CMD_PAGE, 16'h00FF);
		w(CMD_CLEAR_FAULTS, 16'h0000);
		pin(20, 1'b1);
		repeat (50) @(negedge clk);
		chk({14'h0, en}, 16'h0000, "vin off");
		r(CMD_STATUS_BYTE, 16'h0001);
		r(CMD_STATUS_WORD, 16'h2001);
		r(CMD_STATUS_INPUT, 16'h0080);
		chk({15'h0, alert_oe}, 16'h0001, "vin alert");
		w(CMD_ALERT_MASK, 16'h0001);
		w(CMD_CLEAR_FAULTS, 16'h0000);
		pin(20, 1'b1);
		repeat (50) @(negedge clk);
		chk({15'h0, alert_oe}, 16'h0000, "masked");
		$display("input ov done");
		end_sim();
	end
endmodule
